//--- logic/angle_unit_defines.svh
`ifndef ANGLE_UNIT_DEFINES_SVH
`define ANGLE_UNIT_DEFINES_SVH
// Register indices; byte address is four times the index
`define IDX_CTRL_A   13'h1fc0
`define IDX_CTRL_B   13'h1fc1
`define IDX_PERIOD   13'h1fc2
`define IDX_ANGLE    13'h1fc4
`define IDX_AMP      13'h1fc5
`define IDX_CAPTURE  13'h1fc6
`define IDX_SINE     13'h1fc7
`define IDX_CMP_U    13'h1fc8
`define IDX_CMP_V    13'h1fc9
`define IDX_CMP_W    13'h1fca
// Control A fields
`define A_DIR        7
`define A_ORDER      6
`define A_CLK_HI     5
`define A_CLK_LO     4
`define A_MOD3       3
`define A_XFER       2
`define A_CALC       1
`define A_TEN        0
// Control B fields
`define B_START      3
`define B_BUSY       2
`define B_SYNC       1
`define B_IRQSEL     0
// Period register fields, reset value and minimum period
`define P_CORR_HI    15
`define P_CORR_LO    12
`define P_PER_HI     11
`define PERIOD_RST   16'h0010
`define PERIOD_MIN   12'h010
// Angle, prescaler and calculation constants
`define ANGLE_MAX    9'h17f
`define ANGLE_STEPS  10'h180
`define ANGLE_HALF   9'h0c0
`define PHASE_120    10'h080
`define PHASE_240    10'h100
`define PRESC_BASE   6'h08
`define CALC_CYCLES  6'h23
`endif

//--- logic/angle_unit_pkg.sv
package angle_unit_pkg;
   typedef enum logic [1:0] {
      CALC_IDLE = 2'b01,
      CALC_RUN  = 2'b10
   } calc_t;

   typedef struct packed {
      logic [7:0]  ctrlA;
      logic        sync;
      logic        irqSel;
      logic [15:0] period;
      logic [8:0]  angle;
      logic [15:0] voltage_magnitude;
      logic [8:0]  capture;
      logic [5:0]  presc;
      logic [12:0] stepCnt;
      logic [3:0]  grp;
      calc_t       soft_calc_start;
      logic [5:0]  calcCnt;
      logic [8:0]  calcAngle;
      logic [15:0] resU;
      logic [15:0] resV;
      logic [15:0] resW;
      logic [15:0] cmpU;
      logic [15:0] cmpV;
      logic [15:0] cmpW;
      logic        irq;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } state_t;
endpackage : angle_unit_pkg

//--- logic/electrical_angle_waveform_unit.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "angle_unit_defines.svh"
module electrical_angle_waveform_unit
   import angle_unit_pkg::*;
#(
   parameter int DATA_W = 16
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        posDetect,
   input  wire logic [15:0] pwmPeriod,
   output logic      [15:0] dutyU,
   output logic      [15:0] dutyV,
   output logic      [15:0] dutyW,
   output logic             angleIrq
);

   if (DATA_W != 16) begin : g_chk
      $error("DATA_W must be 16");
   end

   logic [1:0]        rstSync_r;
   logic              rstn;
   state_t            r;
   state_t            s;
   logic [DATA_W-1:0] sineRam [0:`ANGLE_MAX];
   logic [12:0]       idx;
   logic              wrAcc;
   logic              setup;
   logic [11:0]       perM;
   logic [12:0]       target;
   logic [5:0]        mask;
   logic              tick;
   logic              stepDone;
   logic              calcDone;
   logic              start;
   logic [8:0]        aV;
   logic [8:0]        aW;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rstSync_r <= 2'b00;
      end else begin
         rstSync_r <= {rstSync_r[0], 1'b1};
      end
   end
   assign rstn = rstSync_r[1];

   function automatic logic [8:0] phaseAngle(input logic [8:0] a,
                                             input logic [9:0] off);
      logic [9:0] sum;
      sum = {1'b0, a} + off;
      if (sum >= `ANGLE_STEPS) begin
         sum = sum - `ANGLE_STEPS;
      end
      return sum[8:0];
   endfunction : phaseAngle

   function automatic logic [15:0] shape(input logic [15:0] ramv,
                                         input logic [15:0] voltage_magnitude,
                                         input logic [15:0] per,
                                         input logic        mod3,
                                         input logic [8:0]  a);
      logic [31:0] prod;
      logic [15:0] term;
      prod = ramv * voltage_magnitude;
      term = prod[31:16];
      if (term > per) begin
         term = per;
      end
      if (!mod3) begin
         return term;
      end else if (a < `ANGLE_HALF) begin
         return (per >> 1) + (term >> 1);
      end else begin
         return (per >> 1) - (term >> 1);
      end
   endfunction : shape

   assign idx   = paddr[14:2];
   assign setup = psel && !penable && !r.pready;
   assign wrAcc = psel && penable && pready && pwrite;

   always_ff @(posedge clock) begin
      if (wrAcc && idx == `IDX_SINE) begin
         sineRam[r.angle] <= pwdata[DATA_W-1:0];
      end
   end

   assign perM = (r.period[`P_PER_HI:0] < `PERIOD_MIN) ?
                 `PERIOD_MIN : r.period[`P_PER_HI:0];
   assign aV = phaseAngle(r.calcAngle,
                          r.ctrlA[`A_ORDER] ? `PHASE_240 : `PHASE_120);
   assign aW = phaseAngle(r.calcAngle,
                          r.ctrlA[`A_ORDER] ? `PHASE_120 : `PHASE_240);

   always_comb begin
      s = r;
      // Count clock prescaler, fc/(8 << code)
      mask = (`PRESC_BASE << r.ctrlA[`A_CLK_HI:`A_CLK_LO]) - 6'h01;
      tick = r.ctrlA[`A_TEN] && ((r.presc & mask) == mask);
      target = {1'b0, perM}
               + {12'h000, (r.grp < r.period[`P_CORR_HI:`P_CORR_LO])};
      stepDone = tick && (r.stepCnt + 13'h0001 >= target);
      calcDone = (r.soft_calc_start == CALC_RUN) && (r.calcCnt == `CALC_CYCLES - 6'h01);
      start = 1'b0;
      s.pready = setup;
      s.pslverr = 1'b0;
      s.irq = 1'b0;
      if (r.ctrlA[`A_TEN]) begin
         s.presc = r.presc + 6'h01;
         if (tick) begin
            s.stepCnt = stepDone ? 13'h0000 : r.stepCnt + 13'h0001;
         end
         if (stepDone) begin
            s.grp = r.grp + 4'h1;
            if (r.ctrlA[`A_DIR]) begin
               s.angle = (r.angle == 9'h000) ? `ANGLE_MAX : r.angle - 9'h001;
            end else begin
               s.angle = (r.angle == `ANGLE_MAX) ? 9'h000 : r.angle + 9'h001;
            end
            start = !r.sync;
            s.irq = !r.irqSel;
         end
      end
      if (posDetect) begin
         s.capture = r.angle;
      end
      if (calcDone) begin
         s.soft_calc_start = CALC_IDLE;
         s.irq = s.irq || r.irqSel;
         s.resU = shape(sineRam[r.calcAngle], r.voltage_magnitude, pwmPeriod,
                        r.ctrlA[`A_MOD3], r.calcAngle);
         s.resV = shape(sineRam[aV], r.voltage_magnitude, pwmPeriod, r.ctrlA[`A_MOD3], aV);
         s.resW = shape(sineRam[aW], r.voltage_magnitude, pwmPeriod, r.ctrlA[`A_MOD3], aW);
         if (r.ctrlA[`A_XFER]) begin
            s.cmpU = s.resU;
            s.cmpV = s.resV;
            s.cmpW = s.resW;
         end
      end else if (r.soft_calc_start == CALC_RUN) begin
         s.calcCnt = r.calcCnt + 6'h01;
      end
      if (setup) begin
         unique case (idx)
            `IDX_CTRL_A:  s.prdata = {24'h0, r.ctrlA};
            `IDX_CTRL_B:  s.prdata = {28'h0, 1'b0, (r.soft_calc_start == CALC_RUN),
                                      r.sync, r.irqSel};
            `IDX_PERIOD:  s.prdata = {16'h0, r.period};
            `IDX_ANGLE:   s.prdata = {23'h0, r.angle};
            `IDX_AMP:     s.prdata = {16'h0, r.voltage_magnitude};
            `IDX_CAPTURE: s.prdata = {23'h0, r.capture};
            `IDX_SINE:    s.prdata = 32'h0;
            `IDX_CMP_U:   s.prdata = {16'h0, r.resU};
            `IDX_CMP_V:   s.prdata = {16'h0, r.resV};
            `IDX_CMP_W:   s.prdata = {16'h0, r.resW};
            default: begin
               s.prdata = 32'h0;
               s.pslverr = 1'b1;
            end
         endcase
      end
      if (wrAcc) begin
         unique case (idx)
            `IDX_CTRL_A: begin
               s.ctrlA = pwdata[7:0];
               if (!pwdata[`A_TEN]) begin
                  s.angle = 9'h000;
                  s.presc = 6'h00;
                  s.stepCnt = 13'h0000;
                  s.grp = 4'h0;
               end
            end
            `IDX_CTRL_B: begin
               s.sync = pwdata[`B_SYNC];
               s.irqSel = pwdata[`B_IRQSEL];
               start = start || pwdata[`B_START];
            end
            `IDX_PERIOD: s.period = pwdata[15:0];
            `IDX_ANGLE: begin
               if (pwdata[8:0] <= `ANGLE_MAX && pwdata[15:9] == 7'h00) begin
                  s.angle = pwdata[8:0];
                  start = start || !r.sync;
               end
            end
            `IDX_AMP: s.voltage_magnitude = pwdata[15:0];
            `IDX_CMP_U: if (!r.ctrlA[`A_XFER]) s.cmpU = pwdata[15:0];
            `IDX_CMP_V: if (!r.ctrlA[`A_XFER]) s.cmpV = pwdata[15:0];
            `IDX_CMP_W: if (!r.ctrlA[`A_XFER]) s.cmpW = pwdata[15:0];
            default: ;
         endcase
      end
      if (start && r.ctrlA[`A_CALC]) begin
         s.soft_calc_start = CALC_RUN;
         s.calcCnt = 6'h00;
         s.calcAngle = s.angle;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         r <= '{ctrlA: 8'h00, sync: 1'b0, irqSel: 1'b0,
                period: `PERIOD_RST, angle: 9'h000, voltage_magnitude: 16'h0000,
                capture: 9'h000, presc: 6'h00, stepCnt: 13'h0000,
                grp: 4'h0, soft_calc_start: CALC_IDLE, calcCnt: 6'h00,
                calcAngle: 9'h000, resU: 16'h0000, resV: 16'h0000,
                resW: 16'h0000, cmpU: 16'h0000, cmpV: 16'h0000,
                cmpW: 16'h0000, irq: 1'b0, prdata: 32'h0,
                pready: 1'b0, pslverr: 1'b0};
      end else begin
         r <= s;
      end
   end

   assign prdata   = r.prdata;
   assign pready   = r.pready;
   assign pslverr  = r.pslverr;
   assign dutyU    = r.cmpU;
   assign dutyV    = r.cmpV;
   assign dutyW    = r.cmpW;
   assign angleIrq = r.irq;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence s_angleWr;
      wrAcc && idx == `IDX_ANGLE && !r.ctrlA[`A_TEN];
   endsequence

   property p_angleRange;
      r.angle <= `ANGLE_MAX;
   endproperty
   a_angleRange: assert property (p_angleRange)
      else $error("Angle above range");

   property p_badAngle;
      s_angleWr and (pwdata[8:0] > `ANGLE_MAX) |=> $stable(r.angle);
   endproperty
   a_badAngle: assert property (p_badAngle)
      else $error("Out of range angle write took effect");

   property p_calcLen;
      $fell(r.soft_calc_start == CALC_RUN) |-> $past(r.calcCnt) == `CALC_CYCLES - 6'h01;
   endproperty
   a_calcLen: assert property (p_calcLen)
      else $error("Calculation length wrong");

   property p_softStart;
      wrAcc && idx == `IDX_CTRL_B && pwdata[`B_START] && r.ctrlA[`A_CALC]
         |=> r.soft_calc_start == CALC_RUN && r.calcCnt == 6'h00;
   endproperty
   a_softStart: assert property (p_softStart)
      else $error("Software start ignored");

   property p_busyRead;
      setup && idx == `IDX_CTRL_B
         |=> prdata[`B_BUSY] == $past(r.soft_calc_start == CALC_RUN) && pready;
   endproperty
   a_busyRead: assert property (p_busyRead)
      else $error("Busy flag read wrong");

   property p_disable;
      wrAcc && idx == `IDX_CTRL_A && !pwdata[`A_TEN] |=> r.angle == 9'h000;
   endproperty
   a_disable: assert property (p_disable)
      else $error("Angle not cleared on disable");

   property p_capture;
      posDetect |=> r.capture == $past(r.angle);
   endproperty
   a_capture: assert property (p_capture)
      else $error("Capture missed");

   property p_limit;
      calcDone && !r.ctrlA[`A_MOD3] && r.ctrlA[`A_XFER]
         |=> dutyU <= $past(pwmPeriod);
   endproperty
   a_limit: assert property (p_limit)
      else $error("Duty above PWM period");

   property p_cmpLock;
      wrAcc && idx == `IDX_CMP_U && r.ctrlA[`A_XFER] && !calcDone
         |=> $stable(dutyU);
   endproperty
   a_cmpLock: assert property (p_cmpLock)
      else $error("Compare write not blocked");

   property p_irqStep;
      stepDone && !r.irqSel |=> angleIrq;
   endproperty
   a_irqStep: assert property (p_irqStep)
      else $error("Step interrupt missing");

   property p_calcIrq;
      calcDone && r.irqSel |=> angleIrq;
   endproperty
   a_calcIrq: assert property (p_calcIrq)
      else $error("Calculation interrupt missing");

   property p_timerStop;
      !r.ctrlA[`A_TEN] && !wrAcc |=> $stable(r.angle);
   endproperty
   a_timerStop: assert property (p_timerStop)
      else $error("Angle moved while timer disabled");

   property p_countDown;
      stepDone && r.ctrlA[`A_DIR] && r.angle != 9'h000 && !wrAcc
         |=> r.angle == $past(r.angle) - 9'h001;
   endproperty
   a_countDown: assert property (p_countDown)
      else $error("Down count step wrong");

   property p_xferDuty;
      calcDone && r.ctrlA[`A_XFER]
         |=> dutyU == r.resU && dutyV == r.resV && dutyW == r.resW;
   endproperty
   a_xferDuty: assert property (p_xferDuty)
      else $error("Result not transferred to duty");

endmodule : electrical_angle_waveform_unit

//--- verif/testbench.sv
`timescale 1ns/1ps
`include "angle_unit_defines.svh"
module testbench;
   typedef struct packed {
      logic        w;
      logic [12:0] idx;
      logic [15:0] d;
      logic [15:0] e;
      logic        s;
   } row_t;
   typedef struct packed {
      logic [15:0] a;
      logic [47:0] e;
   } calc_row_t;
   logic        clock      = 1'b0;
   logic        resetn     = 1'b0;
   logic        psel       = 1'b0;
   logic        penable    = 1'b0;
   logic        pwrite     = 1'b0;
   logic [15:0] paddr      = 16'h0000;
   logic [31:0] pwdata     = 32'h00000000;
   logic        posDetect  = 1'b0;
   logic [15:0] pwmPeriod  = 16'h3000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [15:0] dutyU;
   logic [15:0] dutyV;
   logic [15:0] dutyW;
   logic        angleIrq;
   logic [31:0] rd;
   logic        err;
   int          mismatches = 0;
   int          n_compared = 0;
   int          cycles     = 0;
   int          n;
   int          sum;
   int          longs;
   logic [15:0] sineAddr[3] = '{16'h0010, 16'h0090, 16'h0110};
   logic [15:0] sineData[3] = '{16'h8000, 16'h4000, 16'h2000};
   row_t        rows[16] = '{
      '{1'b0, `IDX_CTRL_A, 16'h0000, 16'h0000, 1'b0},
      '{1'b0, `IDX_PERIOD, 16'h0000, 16'h0010, 1'b0},
      '{1'b0, `IDX_CTRL_B, 16'h0000, 16'h0000, 1'b0},
      '{1'b0, 13'h1fc3, 16'h0000, 16'h0000, 1'b1},
      '{1'b1, `IDX_PERIOD, 16'h3020, 16'h0000, 1'b0},
      '{1'b0, `IDX_PERIOD, 16'h0000, 16'h3020, 1'b0},
      '{1'b1, `IDX_CTRL_B, 16'h000b, 16'h0000, 1'b0},
      '{1'b0, `IDX_CTRL_B, 16'h0000, 16'h0003, 1'b0},
      '{1'b1, `IDX_CTRL_A, 16'h00f8, 16'h0000, 1'b0},
      '{1'b0, `IDX_CTRL_A, 16'h0000, 16'h00f8, 1'b0},
      '{1'b1, `IDX_ANGLE, 16'h017f, 16'h0000, 1'b0},
      '{1'b0, `IDX_ANGLE, 16'h0000, 16'h017f, 1'b0},
      '{1'b1, `IDX_ANGLE, 16'h0180, 16'h0000, 1'b0},
      '{1'b0, `IDX_ANGLE, 16'h0000, 16'h017f, 1'b0},
      '{1'b1, `IDX_CTRL_A, 16'h0000, 16'h0000, 1'b0},
      '{1'b0, `IDX_ANGLE, 16'h0000, 16'h0000, 1'b0}};
   calc_row_t   calcRows[4] = '{
      '{16'h0006, 48'h3000_2000_1000},
      '{16'h0046, 48'h3000_1000_2000},
      '{16'h000e, 48'h3000_2800_1000},
      '{16'h004e, 48'h3000_1000_2800}};

   electrical_angle_waveform_unit electrical_angle_waveform_unit_inst (
      .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .posDetect(posDetect),
      .pwmPeriod(pwmPeriod), .dutyU(dutyU), .dutyV(dutyV), .dutyW(dutyW),
      .angleIrq(angleIrq));

   always #10 clock = ~clock;

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         $display("FAIL %0t timeout", $time);
         final_report;
      end
   end

   task automatic check(input logic [47:0] got, input logic [47:0] exp,
                        input string what);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic apb(input logic w, input logic [12:0] idx,
                      input logic [15:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {1'b0, idx, 2'b00};
      pwdata <= {16'h0000, d};
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
      check(48'(k), 48'h1, "pready");
   endtask : apb

   task automatic wr(input logic [12:0] idx, input logic [15:0] d);
      apb(1'b1, idx, d);
   endtask : wr

   task automatic rdc(input logic [12:0] idx, input logic [15:0] e);
      apb(1'b0, idx, 16'h0000);
      check(48'(rd), 48'(e), "read");
   endtask : rdc

   task automatic wait_irq(output int cnt);
      cnt = 0;
      do begin
         @(posedge clock);
         cnt++;
      end while (angleIrq !== 1'b1 && cnt < 3000);
   endtask : wait_irq

   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   initial begin
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      repeat (3) @(posedge clock);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].idx, rows[i].d);
         if (!rows[i].w)
            check({15'h0, err, rd}, {15'h0, rows[i].s, 16'h0, rows[i].e},
                  "row");
      end
      $display("register rows done");
      wr(`IDX_CTRL_B, 16'h0000);
      wr(`IDX_PERIOD, 16'h0005);
      for (int c = 0; c < 4; c++) begin
         wr(`IDX_CTRL_A, 16'h0000);
         wr(`IDX_CTRL_A, 16'((c << 4) | 1));
         wait_irq(n);
         wait_irq(n);
         check(48'(n), 48'(128 << c), "step");
      end
      wr(`IDX_CTRL_A, 16'h0000);
      wr(`IDX_PERIOD, 16'h4010);
      wr(`IDX_CTRL_A, 16'h0001);
      wait_irq(n);
      sum = 0;
      longs = 0;
      repeat (16) begin
         wait_irq(n);
         sum += n;
         if (n == 136)
            longs++;
      end
      check(48'(sum), 48'd2080, "group");
      check(48'(longs), 48'd4, "long steps");
      wr(`IDX_ANGLE, 16'h017f);
      wait_irq(n);
      rdc(`IDX_ANGLE, 16'h0000);
      wr(`IDX_CTRL_A, 16'h0081);
      wait_irq(n);
      wr(`IDX_ANGLE, 16'h0000);
      wait_irq(n);
      rdc(`IDX_ANGLE, 16'h017f);
      wait_irq(n);
      rdc(`IDX_ANGLE, 16'h017e);
      wr(`IDX_CTRL_A, 16'h0080);
      rdc(`IDX_ANGLE, 16'h0000);
      repeat (300) @(posedge clock);
      rdc(`IDX_ANGLE, 16'h0000);
      $display("timer done");
      wr(`IDX_ANGLE, 16'h00a5);
      posDetect <= 1'b1;
      @(posedge clock);
      posDetect <= 1'b0;
      @(posedge clock);
      rdc(`IDX_CAPTURE, 16'h00a5);
      $display("capture done");
      wr(`IDX_CTRL_A, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         wr(`IDX_ANGLE, sineAddr[i]);
         wr(`IDX_SINE, sineData[i]);
      end
      wr(`IDX_AMP, 16'h8000);
      wr(`IDX_CTRL_B, 16'h0001);
      foreach (calcRows[i]) begin
         wr(`IDX_CTRL_A, calcRows[i].a);
         wr(`IDX_ANGLE, 16'h0010);
         rdc(`IDX_CTRL_B, 16'h0005);
         wait_irq(n);
         check(48'(n > 27 && n < 37), 48'h1, "calc time");
         repeat (2) @(posedge clock);
         check({dutyU, dutyV, dutyW}, calcRows[i].e, "duty");
      end
      wr(`IDX_CMP_U, 16'h0123);
      check(48'(dutyU), 48'h3000, "held duty");
      rdc(`IDX_CMP_V, 16'h1000);
      wr(`IDX_CTRL_A, 16'h0002);
      wr(`IDX_CMP_U, 16'h0123);
      check(48'(dutyU), 48'h0123, "soft duty");
      $display("calculation done");
      wr(`IDX_CTRL_B, 16'h0003);
      wr(`IDX_ANGLE, 16'h0020);
      rdc(`IDX_CTRL_B, 16'h0003);
      wr(`IDX_CTRL_B, 16'h000b);
      rdc(`IDX_CTRL_B, 16'h0007);
      wait_irq(n);
      rdc(`IDX_CTRL_B, 16'h0003);
      $display("soft start done");
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      check(48'(dutyU), 48'h0, "reset duty");
      resetn <= 1'b1;
      repeat (3) @(posedge clock);
      rdc(`IDX_PERIOD, 16'h0010);
      rdc(`IDX_CTRL_A, 16'h0000);
      $display("reset done");
      final_report;
   end
endmodule : testbench
